/* include/sjt_defines.vh */
// Constants for the SRAM scan test port: instruction codes, TAP states, widths, FIFO depth.
// Assumes inclusion by bare name from design files; holds definitions only.
`ifndef SJT_DEFINES_VH
`define SJT_DEFINES_VH

// Instruction register
`define SJT_IR_W 3
`define SJT_IR_EXTEST 3'h0
`define SJT_IR_IDCODE 3'h1
`define SJT_IR_SAMPLEZ 3'h2
`define SJT_IR_SAMPLE 3'h4
`define SJT_IR_BYPASS 3'h7
`define SJT_IR_CAPTURE 2'h1

// Register widths
`define SJT_ID_W 32
`define SJT_BSR_W 68

// Arbitrary neutral identification code, not any real maker's value
`define SJT_IDCODE_VAL 32'h0a5a_5001

// TAP controller states
`define SJT_ST_W 4
`define SJT_ST_TLR 4'h0
`define SJT_ST_RTI 4'h1
`define SJT_ST_SELDR 4'h2
`define SJT_ST_CAPDR 4'h3
`define SJT_ST_SHDR 4'h4
`define SJT_ST_EX1DR 4'h5
`define SJT_ST_PADR 4'h6
`define SJT_ST_EX2DR 4'h7
`define SJT_ST_UPDR 4'h8
`define SJT_ST_SELIR 4'h9
`define SJT_ST_CAPIR 4'ha
`define SJT_ST_SHIR 4'hb
`define SJT_ST_EX1IR 4'hc
`define SJT_ST_PAIR 4'hd
`define SJT_ST_EX2IR 4'he
`define SJT_ST_UPIR 4'hf

// Captured-sample FIFO
`define SJT_FIFO_DEPTH 32
`define SJT_FIFO_AW 5

`endif

/* logic/sjt_fifo.v */
// Small synchronous FIFO holding captured boundary snapshots.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sjt_fifo #(
   parameter WIDTH = 68,
   parameter DEPTH = 32,
   parameter AW = 5
) (
   // Clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // Fill side
   input wire in_valid_in,
   input wire [WIDTH-1:0] in_data_in,
   output wire in_ready_out,
   // Drain side
   output wire out_valid_out,
   output reg [WIDTH-1:0] out_data_out,
   input wire out_ready_in
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   reg out_valid_r;
   wire do_wr;
   wire do_rd;
   wire load_out;

   // The output register counts as one of the words, so the total stays at DEPTH
   wire [AW:0] held;
   assign held = count_r + {{AW{1'b0}}, out_valid_r};
   assign in_ready_out = (held != DEPTH[AW:0]);
   assign do_wr = in_valid_in && in_ready_out;
   // Output register refills whenever it is empty or being taken
   assign load_out = (!out_valid_r || out_ready_in) && (count_r != {(AW+1){1'b0}});
   assign do_rd = load_out;
   assign out_valid_out = out_valid_r;

   always @(posedge clk_sys_in) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= in_data_in;
      end
   end

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         out_valid_r <= 1'b0;
         out_data_out <= {WIDTH{1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
            out_data_out <= mem_r[rd_ptr_r];
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - 1'b1;
         end
         if (do_rd) begin
            out_valid_r <= 1'b1;
         end else if (out_ready_in) begin
            out_valid_r <= 1'b0;
         end
      end
   end
endmodule

/* logic/sjt_tap.v */
// Reduced boundary-scan test access port for a synchronous SRAM.
// Assumes the scan pins arrive from outside the clk_sys_in domain and are
// oversampled; the test clock is far slower than clk_sys_in.
`timescale 1ns/1ps
`include "sjt_defines.vh"

// How it works
// - MSB next to data in, LSB drives out
// - Capture-DR under IDCODE loads 32-bit code
// - Hardwired code shifts out in Shift-DR
// - Three-bit instruction, three codes reserved
// - Shifted instruction takes effect at Update-IR
// - Port never drives memory, only observes
// - EXTEST captures the ring, never drives it
// - All-zero code samples and floats outputs
// - IDCODE loaded at reset and Test-Logic-Reset
// - Capture-and-float scans ring, floats outputs
// - SAMPLE snapshots pins at Capture-DR
// - Shift-DR shifts captured ring values out
// - Update-DR under SAMPLE acts like pause
// - BYPASS puts one-bit register in path
// - Fixed encodings; 011, 101, 110 reserved
// - Sample on rising, drive out falling
// - Five high mode-select edges reset port
// - Capture-IR loads binary 01 in LSBs
module sjt_tap #(
   parameter BSR_W = `SJT_BSR_W,
   parameter FIFO_DEPTH = `SJT_FIFO_DEPTH,
   parameter FIFO_AW = `SJT_FIFO_AW
) (
   // System clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // Scan pins
   input wire test_clock_in,
   input wire mode_select_in,
   input wire scan_data_in,
   output reg scan_data_out,
   output reg scan_data_oe_out,
   // Observed I/O ring
   input wire [BSR_W-1:0] io_ring_in,
   // Memory output float request
   output reg mem_float_out,
   // Captured snapshot stream
   output wire snap_valid_out,
   output wire [BSR_W-1:0] snap_data_out,
   input wire snap_ready_in,
   // State visibility
   output reg [`SJT_ST_W-1:0] tap_state_out,
   output reg [`SJT_IR_W-1:0] instr_out
);
   // Two-flop synchronisers on all pins from the test domain
   reg tck_m_r, tck_s_r, tck_d_r;
   reg tms_m_r, tms_s_r;
   reg tdi_m_r, tdi_s_r;
   reg [BSR_W-1:0] ring_m_r, ring_s_r;

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         tck_m_r <= 1'b0;
         tck_s_r <= 1'b0;
         tck_d_r <= 1'b0;
         tms_m_r <= 1'b1;
         tms_s_r <= 1'b1;
         tdi_m_r <= 1'b1;
         tdi_s_r <= 1'b1;
         ring_m_r <= {BSR_W{1'b0}};
         ring_s_r <= {BSR_W{1'b0}};
      end else begin
         tck_m_r <= test_clock_in;
         tck_s_r <= tck_m_r;
         tck_d_r <= tck_s_r;
         tms_m_r <= mode_select_in;
         tms_s_r <= tms_m_r;
         tdi_m_r <= scan_data_in;
         tdi_s_r <= tdi_m_r;
         ring_m_r <= io_ring_in;
         ring_s_r <= ring_m_r;
      end
   end

   // Edges of the test clock; pins are sampled on rise, output moves on fall
   wire tck_rise = tck_s_r && !tck_d_r;
   wire tck_fall = !tck_s_r && tck_d_r;

   reg [`SJT_ST_W-1:0] state_nxt;
   reg [`SJT_IR_W-1:0] ir_shift_r;
   reg bypass_r;
   reg [`SJT_ID_W-1:0] id_r;
   reg [BSR_W-1:0] bsr_r;
   reg shift_bit;
   wire fifo_ready;

   // Standard sixteen-state sequence; a run of five high mode-select edges
   // from any state lands in Test-Logic-Reset.
   always @* begin
      state_nxt = tap_state_out;
      case (tap_state_out)
         `SJT_ST_TLR: state_nxt = tms_s_r ? `SJT_ST_TLR : `SJT_ST_RTI;
         `SJT_ST_RTI: state_nxt = tms_s_r ? `SJT_ST_SELDR : `SJT_ST_RTI;
         `SJT_ST_SELDR: state_nxt = tms_s_r ? `SJT_ST_SELIR : `SJT_ST_CAPDR;
         `SJT_ST_CAPDR: state_nxt = tms_s_r ? `SJT_ST_EX1DR : `SJT_ST_SHDR;
         `SJT_ST_SHDR: state_nxt = tms_s_r ? `SJT_ST_EX1DR : `SJT_ST_SHDR;
         `SJT_ST_EX1DR: state_nxt = tms_s_r ? `SJT_ST_UPDR : `SJT_ST_PADR;
         `SJT_ST_PADR: state_nxt = tms_s_r ? `SJT_ST_EX2DR : `SJT_ST_PADR;
         `SJT_ST_EX2DR: state_nxt = tms_s_r ? `SJT_ST_UPDR : `SJT_ST_SHDR;
         `SJT_ST_UPDR: state_nxt = tms_s_r ? `SJT_ST_SELDR : `SJT_ST_RTI;
         `SJT_ST_SELIR: state_nxt = tms_s_r ? `SJT_ST_TLR : `SJT_ST_CAPIR;
         `SJT_ST_CAPIR: state_nxt = tms_s_r ? `SJT_ST_EX1IR : `SJT_ST_SHIR;
         `SJT_ST_SHIR: state_nxt = tms_s_r ? `SJT_ST_EX1IR : `SJT_ST_SHIR;
         `SJT_ST_EX1IR: state_nxt = tms_s_r ? `SJT_ST_UPIR : `SJT_ST_PAIR;
         `SJT_ST_PAIR: state_nxt = tms_s_r ? `SJT_ST_EX2IR : `SJT_ST_PAIR;
         `SJT_ST_EX2IR: state_nxt = tms_s_r ? `SJT_ST_UPIR : `SJT_ST_SHIR;
         `SJT_ST_UPIR: state_nxt = tms_s_r ? `SJT_ST_SELDR : `SJT_ST_RTI;
         default: state_nxt = `SJT_ST_TLR;
      endcase
   end

   // Instruction groups; reserved codes fall to bypass so the chain stays intact
   wire ins_id = (instr_out == `SJT_IR_IDCODE);
   wire ins_ring = (instr_out == `SJT_IR_EXTEST) || (instr_out == `SJT_IR_SAMPLEZ) ||
      (instr_out == `SJT_IR_SAMPLE);
   wire ins_float = (instr_out == `SJT_IR_EXTEST) || (instr_out == `SJT_IR_SAMPLEZ);

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         tap_state_out <= `SJT_ST_TLR;
         instr_out <= `SJT_IR_IDCODE;
         ir_shift_r <= `SJT_IR_IDCODE;
         bypass_r <= 1'b0;
         id_r <= {`SJT_ID_W{1'b0}};
         bsr_r <= {BSR_W{1'b0}};
      end else if (tck_rise) begin
         tap_state_out <= state_nxt;
         case (tap_state_out)
            `SJT_ST_TLR: begin
               instr_out <= `SJT_IR_IDCODE;
            end
            `SJT_ST_CAPIR: begin
               ir_shift_r <= {instr_out[`SJT_IR_W-1], `SJT_IR_CAPTURE};
            end
            `SJT_ST_SHIR: begin
               ir_shift_r <= {tdi_s_r, ir_shift_r[`SJT_IR_W-1:1]};
            end
            `SJT_ST_UPIR: begin
               instr_out <= ir_shift_r;
            end
            `SJT_ST_CAPDR: begin
               bypass_r <= 1'b0;
               if (ins_id) begin
                  id_r <= `SJT_IDCODE_VAL;
               end
               if (ins_ring) begin
                  bsr_r <= ring_s_r;
               end
            end
            `SJT_ST_SHDR: begin
               // Data enters at the MSB end and leaves from bit 0
               if (ins_id) begin
                  id_r <= {tdi_s_r, id_r[`SJT_ID_W-1:1]};
               end else if (ins_ring) begin
                  bsr_r <= {tdi_s_r, bsr_r[BSR_W-1:1]};
               end else begin
                  bypass_r <= tdi_s_r;
               end
            end
            // Update-DR changes nothing: no preload, nothing driven from the chain
            default: begin
               instr_out <= instr_out;
            end
         endcase
         // The instruction must already read IDCODE on arrival in Test-Logic-Reset
         if (state_nxt == `SJT_ST_TLR) begin
            instr_out <= `SJT_IR_IDCODE;
         end
      end
   end

   // Serial output source, moved on the falling test-clock edge
   always @* begin
      if (tap_state_out == `SJT_ST_SHIR) begin
         shift_bit = ir_shift_r[0];
      end else if (ins_id) begin
         shift_bit = id_r[0];
      end else if (ins_ring) begin
         shift_bit = bsr_r[0];
      end else begin
         shift_bit = bypass_r;
      end
   end

   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         scan_data_out <= 1'b0;
         scan_data_oe_out <= 1'b0;
         mem_float_out <= 1'b0;
      end else begin
         if (tck_fall) begin
            scan_data_out <= shift_bit;
            scan_data_oe_out <= (tap_state_out == `SJT_ST_SHIR) ||
               (tap_state_out == `SJT_ST_SHDR);
         end
         // Float follows the active instruction; the port never drives memory pins
         mem_float_out <= ins_float;
      end
   end

   // Each ring capture is also offered as a snapshot word; a full queue drops it
   // rather than stall the scan, because the test clock cannot be held.
   wire snap_push = tck_rise && (tap_state_out == `SJT_ST_CAPDR) && ins_ring;

   sjt_fifo #(
      .WIDTH(BSR_W),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_snap_fifo (
      .clk_sys_in(clk_sys_in),
      .reset_n_in(reset_n_in),
      .in_valid_in(snap_push),
      .in_data_in(ring_s_r),
      .in_ready_out(fifo_ready),
      .out_valid_out(snap_valid_out),
      .out_data_out(snap_data_out),
      .out_ready_in(snap_ready_in)
   );

   wire snap_drop = snap_push && !fifo_ready;
   reg snap_overflow_r;
   always @(posedge clk_sys_in) begin
      if (!reset_n_in) begin
         snap_overflow_r <= 1'b0;
      end else if (snap_drop) begin
         snap_overflow_r <= 1'b1;
      end
   end
endmodule

/* test/sjt_scan_ctl.sv */
// Board-side scan controller model: test clock, mode select, serial data.
// Assumes the device moves its serial output after falling test-clock edges.
`timescale 1ns/1ps
module sjt_scan_ctl (
   // Scan pins toward the device
   output reg tck_out,
   output reg tms_out,
   output reg tdi_out,
   input wire tdo_in
);
   // Clock rests low between frames; mode select and data rest high as pulled up
   initial begin
      tck_out = 1'b0;
      tms_out = 1'b1;
      tdi_out = 1'b1;
   end
   // One 125 ns period; output sampled late in the low phase, well after it settles
   task step(input m, input d, output o);
      begin
         tms_out = m;
         tdi_out = d;
         #62.5;
         o = tdo_in;
         tck_out = 1'b1;
         #62.5;
         tck_out = 1'b0;
      end
   endtask
endmodule

/* test/sjt_tap_monitor.sv */
// Concurrent checks on the scan port's status and serial outputs.
// Assumes sjt_defines.vh on the include path; attached by the bind below.
`timescale 1ns/1ps
`include "sjt_defines.vh"
module sjt_tap_monitor (
   // Clock and reset
   input wire clk_sys_in,
   input wire reset_n_in,
   // Watched ports
   input wire test_clock_in,
   input wire scan_data_out,
   input wire scan_data_oe_out,
   input wire mem_float_out,
   input wire snap_valid_out,
   input wire [`SJT_ST_W-1:0] tap_state_out,
   input wire [`SJT_IR_W-1:0] instr_out
);
   // Successors per state, {mode select high, mode select low}
   localparam [127:0] NXT = 128'h21fb_edfd_cbcb_0a21_8476_8654_5493_2101;
   localparam [31:0] ID = `SJT_IDCODE_VAL;
   reg [3:0] st_r;
   wire [7:0] nx = NXT[st_r*8 +: 8];
   wire shdr = tap_state_out == `SJT_ST_SHDR;
   always @(posedge clk_sys_in) st_r <= tap_state_out;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!reset_n_in);
   a_walk_legal: assert property (tap_state_out != st_r |->
      tap_state_out == nx[7:4] || tap_state_out == nx[3:0]) else $error("bad state step");
   a_float_match: assert property ($stable(instr_out)[*3] |->
      mem_float_out == (instr_out == 3'h0 || instr_out == 3'h2)) else $error("float wrong");
   a_reset_idcode: assert property (tap_state_out == `SJT_ST_TLR [*3] |->
      instr_out == `SJT_IR_IDCODE) else $error("no idcode in reset");
   a_instr_at_update: assert property ($changed(instr_out) |->
      $past(tap_state_out) == `SJT_ST_UPIR || tap_state_out == `SJT_ST_UPIR ||
      $past(tap_state_out) == `SJT_ST_TLR || tap_state_out == `SJT_ST_TLR)
      else $error("instr changed outside update");
   a_oe_in_shift: assert property ($rose(scan_data_oe_out) |->
      shdr || tap_state_out == `SJT_ST_SHIR) else $error("oe outside shift");
   a_out_on_fall: assert property ($changed(scan_data_out) |->
      !test_clock_in && !$past(test_clock_in)) else $error("out moved off falling edge");
   a_ir_capture_bit: assert property ($rose(scan_data_oe_out) &&
      tap_state_out == `SJT_ST_SHIR |-> scan_data_out) else $error("ir capture lsb");
   a_id_first_bit: assert property ($rose(scan_data_oe_out) && shdr &&
      instr_out == `SJT_IR_IDCODE |-> scan_data_out == ID[0]) else $error("id lsb");
   a_bypass_zero: assert property ($rose(scan_data_oe_out) && shdr &&
      instr_out == `SJT_IR_BYPASS |-> !scan_data_out) else $error("bypass not cleared");
   a_snap_ring: assert property ($rose(snap_valid_out) |-> instr_out == 3'h0 ||
      instr_out == 3'h2 || instr_out == 3'h4) else $error("snapshot outside ring");
   c_snap: cover property ($rose(snap_valid_out));
   c_upir: cover property (tap_state_out == `SJT_ST_UPIR);
   c_float: cover property (mem_float_out && instr_out == `SJT_IR_EXTEST);
endmodule
bind sjt_tap sjt_tap_monitor u_mon (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
   .test_clock_in(test_clock_in), .scan_data_out(scan_data_out),
   .scan_data_oe_out(scan_data_oe_out), .mem_float_out(mem_float_out),
   .snap_valid_out(snap_valid_out), .tap_state_out(tap_state_out), .instr_out(instr_out));

/* test/sjt_tap_test.sv */
// Self-checking bench for the SRAM scan test port with a controller model.
// Assumes sjt_defines.vh on the include path; the checker binds itself.
`timescale 1ns/1ps
`include "sjt_defines.vh"
module sjt_tap_test;
   reg clk_sys_in = 1'b0;
   reg reset_n_in = 1'b0;
   // Ring is held still during captures, so no captured bit needs ignoring
   reg [67:0] io_ring = 68'h0;
   reg snap_ready = 1'b1;
   reg bit_o;
   wire tck, tms, tdi, tdo, tdo_oe, mem_float, snap_valid;
   wire [67:0] snap_data;
   wire [3:0] state;
   wire [2:0] instr;
   // Released output floats, so a stale level never reads as data
   wire tdo_pin = tdo_oe ? tdo : 1'bz;
   integer n_mismatch = 0;
   integer comparisons = 0;
   always #5 clk_sys_in = ~clk_sys_in;
   sjt_tap u_dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
      .test_clock_in(tck), .mode_select_in(tms), .scan_data_in(tdi), .scan_data_out(tdo),
      .scan_data_oe_out(tdo_oe), .io_ring_in(io_ring), .mem_float_out(mem_float),
      .snap_valid_out(snap_valid), .snap_data_out(snap_data), .snap_ready_in(snap_ready),
      .tap_state_out(state), .instr_out(instr));
   sjt_scan_ctl u_ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_pin));
   task check(input [127:0] got, input [127:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task results;
      begin
         $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
         if (n_mismatch == 0 && comparisons > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   // Argument is {mode select, data in}
   task st(input [1:0] md);
      u_ctl.step(md[1], md[0], bit_o);
   endtask
   task ir_scan(input [2:0] code, output [2:0] cap);
      integer j;
      begin
         st(2'h3); st(2'h3); st(2'h1); st(2'h1);
         for (j = 0; j < 3; j = j + 1) begin
            u_ctl.step(j == 2, code[j], bit_o);
            cap[j] = bit_o;
         end
         st(2'h3); st(2'h1);
      end
   endtask
   // Shifts len+8 bits; the last 8 out are the first 8 in, delayed by the chain
   task dr_scan(input integer len, input [127:0] cap);
      reg [127:0] got;
      integer j;
      begin
         got = 128'h0;
         st(2'h3); st(2'h1); st(2'h1);
         for (j = 0; j < len + 8; j = j + 1) begin
            u_ctl.step(j == len + 7, (j < 8) ? 8'h4b >> j : 1'b1, bit_o);
            got[j] = bit_o;
         end
         st(2'h3); st(2'h1);
         check(got, cap | (128'h4b << len));
      end
   endtask
   task t_codes;
      reg [2:0] cap;
      integer n;
      integer len;
      begin
         for (n = 0; n < 8; n = n + 1) begin
            @(posedge clk_sys_in) #1 io_ring = {n[2:0], 65'h1_2345_6789_abcd_ef01};
            ir_scan(n[2:0], cap);
            check(cap[1:0], 2'h1);
            if (n != 3 && n != 5 && n != 6) check(instr, n[2:0]);
            check(mem_float, n == 0 || n == 2);
            len = (n == 1) ? 32 : ((n == 0 || n == 2 || n == 4) ? 68 : 1);
            dr_scan(len, (n == 1) ? `SJT_IDCODE_VAL : ((len == 68) ? io_ring : 0));
            check(mem_float, n == 0 || n == 2);
         end
      end
   endtask
   task t_tms_reset;
      integer n;
      begin
         st(2'h3); st(2'h1); st(2'h1);
         for (n = 0; n < 5; n = n + 1) st(2'h3);
         check(state, `SJT_ST_TLR);
         check(instr, `SJT_IR_IDCODE);
         st(2'h1);
         dr_scan(32, `SJT_IDCODE_VAL);
      end
   endtask
   // Consumer stalls while 34 snapshots arrive; only the first 32 may be kept
   task t_fifo;
      reg [2:0] cap;
      reg [7:0] k;
      begin
         @(posedge clk_sys_in) #1 snap_ready = 1'b0;
         ir_scan(3'h4, cap);
         for (k = 0; k < 34; k = k + 1) begin
            @(posedge clk_sys_in) #1 io_ring = {60'h0, k};
            st(2'h3); st(2'h1); st(2'h3); st(2'h3); st(2'h1);
         end
         k = 0;
         @(posedge clk_sys_in) #1 snap_ready = 1'b1;
         repeat (100) begin
            @(negedge clk_sys_in);
            if (snap_valid === 1'b1) begin
               check(snap_data, k);
               k = k + 1;
            end
         end
         check(k, `SJT_FIFO_DEPTH);
      end
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_in);
      #1 reset_n_in = 1'b1;
      check({state, instr, tdo_oe, mem_float, snap_valid}, {`SJT_ST_TLR, `SJT_IR_IDCODE, 3'h0});
      st(2'h1);
      dr_scan(32, `SJT_IDCODE_VAL);
      t_codes;
      t_tms_reset;
      t_fifo;
      results;
   end
endmodule
